// ==== common/irq_unit_pkg.sv ====
// Purpose: constants and types shared by the prioritized interrupt unit
// Assumes: 100 MHz clk, AHB-Lite register access, 32-bit data
// Notes: offsets are byte addresses of aligned 32-bit words
// Notes on behaviour
// - one interrupt level, six sources, and a routine in service is never preempted.
// - four sources are on-chip events and two are external request pins.
// - simultaneous unmasked requests are served in the fixed order ext one, par full, par empty, ser in full, ser out empty, ext two.
// - each source has its own enable bit in the mask field and a cleared bit blocks entry.
// - external request one is a level that counts as pending while high and is held until served.
// - external request two is a level of lowest priority that is held until accepted.
// - loading the parallel data register raises the parallel buffer full request.
// - reading the parallel data register raises the parallel buffer empty request.
// - the serial input full request is raised when the input-buffer-full flag becomes set.
// - the serial output empty request is raised when the output-buffer-empty flag becomes set.
// - on entry the hidden machine state, the four accumulators and the arithmetic control word are saved.
// - entry branches into a six-entry table of two-word entries whose base is the vector base register at offset 0x04.
// - every request condition stays visible to branch tests even when masked.
// - the return instruction restores accumulators and hidden state, then resumes the program.
package irq_unit_pkg;
    localparam int NUM_SRC = 6;
    localparam int IDX_W = 3;
    localparam int ADDR_W = 24;
    localparam int ACC_W = 40;
    localparam int DAUC_W = 8;
    localparam int HIDDEN_W = 32;
    localparam int EV_W = 3;

    // priority index, zero is highest
    localparam logic [IDX_W-1:0] SRC_EXT_ONE = 3'h0;
    localparam logic [IDX_W-1:0] SRC_PAR_FULL = 3'h1;
    localparam logic [IDX_W-1:0] SRC_PAR_EMPTY = 3'h2;
    localparam logic [IDX_W-1:0] SRC_SER_IN = 3'h3;
    localparam logic [IDX_W-1:0] SRC_SER_OUT = 3'h4;
    localparam logic [IDX_W-1:0] SRC_EXT_TWO = 3'h5;
    localparam int VEC_SHIFT = 3; // two 32-bit words per entry

    // register byte offsets
    localparam logic [7:0] OFS_MASK = 8'h00;
    localparam logic [7:0] OFS_VECBASE = 8'h04;
    localparam logic [7:0] OFS_COND = 8'h08;
    localparam logic [7:0] OFS_VECADDR = 8'h0C;
    localparam logic [7:0] OFS_EVSTAT = 8'h10;
    localparam logic [7:0] OFS_EVMASK = 8'h14;

    // field positions in the condition register
    localparam int COND_INSERV_BIT = 8;
    localparam int COND_ACT_LSB = 16;

    // event status bits
    localparam int EV_ENTRY = 0;
    localparam int EV_RETURN = 1;
    localparam int EV_STRAY_RET = 2;

    // reset values
    localparam logic [NUM_SRC-1:0] MASK_RST = 6'h00;
    localparam logic [ADDR_W-1:0] VECBASE_RST = 24'h00_0000;
    localparam logic [EV_W-1:0] EVMASK_RST = 3'h0;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HRESP_OKAY = 2'h0;

    typedef enum logic {ST_RUN, ST_SERVICE} svc_state_type;
endpackage

// ==== core/irq_prio_pick.sv ====
// Purpose: fixed-priority picker over the six request lines
// Assumes: bit 0 is the highest priority
// Notes: purely combinational
`timescale 1ns/100ps
`default_nettype none
module irq_prio_pick
    import irq_unit_pkg::*;
(
    input wire logic [NUM_SRC-1:0] req, // masked requests
    output logic found, // any request present
    output logic [IDX_W-1:0] idx // index of the winner
);
    // scan from lowest upward so the highest priority overwrites last
    always_comb begin
        found = 1'b0;
        idx = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                found = 1'b1;
                idx = IDX_W'(i);
            end
        end
    end
endmodule // irq_prio_pick
`default_nettype wire

// ==== core/prioritized_interrupt_unit.sv ====
// Purpose: single-level prioritized interrupt unit with context save
// Assumes: core strobes are on clk; request pins are asynchronous
// Notes: registers reached over AHB-Lite with zero wait states
`timescale 1ns/100ps
`default_nettype none
module prioritized_interrupt_unit
    import irq_unit_pkg::*;
(
    input wire logic clk, // 100 MHz clock
    input wire logic sys_rst, // asynchronous reset, active high
    // AHB-Lite slave
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // slave ready
    output logic [1:0] hresp, // response
    // request sources
    input wire logic ext_irq_one, // external request one pin
    input wire logic ext_irq_two, // external request two pin
    input wire logic parRegLoad, // parallel data register loaded
    input wire logic parRegRead, // parallel data register read
    input wire logic ser_in_full, // serial input buffer full flag
    input wire logic ser_out_empty, // serial output buffer empty flag
    // processor core side
    input wire logic instrBoundary, // an instruction completes this cycle
    input wire logic ireturnExec, // return-from-interrupt executed
    input wire logic [ACC_W-1:0] accIn0, // accumulator 0 live value
    input wire logic [ACC_W-1:0] accIn1, // accumulator 1 live value
    input wire logic [ACC_W-1:0] accIn2, // accumulator 2 live value
    input wire logic [ACC_W-1:0] accIn3, // accumulator 3 live value
    input wire logic [DAUC_W-1:0] daucIn, // arithmetic control live value
    input wire logic [HIDDEN_W-1:0] hiddenIn, // hidden machine state
    output logic vectorTake, // pulse: branch to vectorAddr
    output logic [ADDR_W-1:0] vectorAddr, // vector entry address
    output logic restoreStrobe, // pulse: load saved context back
    output logic [ACC_W-1:0] accSaved0, // saved accumulator 0
    output logic [ACC_W-1:0] accSaved1, // saved accumulator 1
    output logic [ACC_W-1:0] accSaved2, // saved accumulator 2
    output logic [ACC_W-1:0] accSaved3, // saved accumulator 3
    output logic [DAUC_W-1:0] daucSaved, // saved arithmetic control
    output logic [HIDDEN_W-1:0] hiddenSaved, // saved hidden state
    output logic inService, // a routine is running
    output logic [NUM_SRC-1:0] condFlags, // conditions for branch tests
    output logic irq // summary interrupt to the host
);
    // entry address: base plus eight bytes per priority step
    // shifts only; one adder
    function automatic logic [ADDR_W-1:0] vecOf(input logic [ADDR_W-1:0] base,
                                                input logic [IDX_W-1:0] i);
        vecOf = base + {{(ADDR_W-IDX_W-VEC_SHIFT){1'b0}}, i, {VEC_SHIFT{1'b0}}};
    endfunction

    svc_state_type state_q;
    logic [NUM_SRC-1:0] mask_q;
    logic [ADDR_W-1:0] vecBase_q;
    logic [IDX_W-1:0] active_q;
    logic [EV_W-1:0] evStat_q;
    logic [EV_W-1:0] evMask_q;
    // pin synchronisers
    logic ext1Meta_q;
    logic ext1Sync_q;
    logic ext2Meta_q;
    logic ext2Sync_q;
    // pending event latches
    logic parFull_q;
    logic parEmpty_q;
    logic serIn_q;
    logic serOut_q;
    logic serInPrev_q;
    logic serOutPrev_q;
    logic vectorTake_q;
    logic restore_q;
    // decode and bus capture
    logic [NUM_SRC-1:0] cond;
    logic [NUM_SRC-1:0] masked;
    logic pickFound;
    logic [IDX_W-1:0] pickIdx;
    logic enter;
    logic leave;
    logic strayRet;
    logic addrAccept;
    logic wrPend_q;
    logic [7:0] wrAddr_q;
    logic [31:0] rdData_q;
    logic [31:0] rdData_d;
    logic evRead;
    logic [EV_W-1:0] evNext;

    // pins cross into clk through two flops before any use
    // a level dropped early is lost
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ext1Meta_q <= 1'b0;
            ext1Sync_q <= 1'b0;
            ext2Meta_q <= 1'b0;
            ext2Sync_q <= 1'b0;
        end else begin
            ext1Meta_q <= ext_irq_one;
            ext1Sync_q <= ext1Meta_q;
            ext2Meta_q <= ext_irq_two;
            ext2Sync_q <= ext2Meta_q;
        end
    end

    // flag history for the serial set-edge detection
    // resets to the idle level: no false edge
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            serInPrev_q <= 1'b0;
            serOutPrev_q <= 1'b0;
        end else begin
            serInPrev_q <= ser_in_full;
            serOutPrev_q <= ser_out_empty;
        end
    end

    // request conditions; the external ones are plain levels, so no latch
    // four on-chip events, two pins
    assign cond[SRC_EXT_ONE] = ext1Sync_q;
    assign cond[SRC_PAR_FULL] = parFull_q;
    assign cond[SRC_PAR_EMPTY] = parEmpty_q;
    assign cond[SRC_SER_IN] = serIn_q;
    assign cond[SRC_SER_OUT] = serOut_q;
    assign cond[SRC_EXT_TWO] = ext2Sync_q;
    assign condFlags = cond;

    // masking gates entry only, never the visible conditions
    assign masked = cond & mask_q;

    // fixed order: no ties
    irq_prio_pick u_pick (
        .req(masked),
        .found(pickFound),
        .idx(pickIdx)
    );

    // entry at an instruction boundary while idle; no preemption in service
    assign enter = (state_q == ST_RUN) && instrBoundary && pickFound;
    assign leave = (state_q == ST_SERVICE) && ireturnExec;
    assign strayRet = (state_q == ST_RUN) && ireturnExec;

    // on-chip event latches; a new event in the accept cycle survives
    // only the winner is cleared
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            parFull_q <= 1'b0;
            parEmpty_q <= 1'b0;
            serIn_q <= 1'b0;
            serOut_q <= 1'b0;
        end else begin
            if (parRegLoad) begin
                parFull_q <= 1'b1;
            end else if (enter && pickIdx == SRC_PAR_FULL) begin
                parFull_q <= 1'b0;
            end
            if (parRegRead) begin
                parEmpty_q <= 1'b1;
            end else if (enter && pickIdx == SRC_PAR_EMPTY) begin
                parEmpty_q <= 1'b0;
            end
            if (ser_in_full && !serInPrev_q) begin
                serIn_q <= 1'b1;
            end else if (enter && pickIdx == SRC_SER_IN) begin
                serIn_q <= 1'b0;
            end
            if (ser_out_empty && !serOutPrev_q) begin
                serOut_q <= 1'b1;
            end else if (enter && pickIdx == SRC_SER_OUT) begin
                serOut_q <= 1'b0;
            end
        end
    end

    // service state machine
    // no nesting while in service
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= ST_RUN;
            active_q <= '0;
        end else begin
            case (state_q)
                ST_RUN: begin
                    if (enter) begin
                        state_q <= ST_SERVICE;
                        active_q <= pickIdx;
                    end
                end
                ST_SERVICE: begin
                    if (leave) begin
                        state_q <= ST_RUN;
                    end
                end
                default: begin
                    state_q <= ST_RUN;
                end
            endcase
        end
    end
    assign inService = (state_q == ST_SERVICE);

    // vector address and one-cycle branch request
    // held for software to read
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            vectorAddr <= '0;
            vectorTake_q <= 1'b0;
        end else begin
            vectorTake_q <= enter;
            if (enter) begin
                vectorAddr <= vecOf(vecBase_q, pickIdx);
            end
        end
    end
    assign vectorTake = vectorTake_q;

    // context save on entry; the routine saves everything else itself
    // values of the decision cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            accSaved0 <= '0;
            accSaved1 <= '0;
            accSaved2 <= '0;
            accSaved3 <= '0;
            daucSaved <= '0;
            hiddenSaved <= '0;
        end else if (enter) begin
            accSaved0 <= accIn0;
            accSaved1 <= accIn1;
            accSaved2 <= accIn2;
            accSaved3 <= accIn3;
            daucSaved <= daucIn;
            hiddenSaved <= hiddenIn;
        end
    end

    // restore strobe one cycle after the return is seen
    // lines up with inService falling
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            restore_q <= 1'b0;
        end else begin
            restore_q <= leave;
        end
    end
    assign restoreStrobe = restore_q;

    // AHB-Lite: zero wait states, address captured, write done in data phase
    // hsize ignored: words only
    assign addrAccept = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == 2'h3);
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wrPend_q <= 1'b0;
            wrAddr_q <= '0;
        end else begin
            wrPend_q <= addrAccept && hwrite;
            if (addrAccept) begin
                wrAddr_q <= haddr[7:0];
            end
        end
    end

    // software-written steering registers
    // read-only and unmapped writes dropped
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mask_q <= MASK_RST;
            vecBase_q <= VECBASE_RST;
            evMask_q <= EVMASK_RST;
        end else if (wrPend_q) begin
            case (wrAddr_q)
                OFS_MASK: mask_q <= hwdata[NUM_SRC-1:0];
                OFS_VECBASE: vecBase_q <= hwdata[ADDR_W-1:0];
                OFS_EVMASK: evMask_q <= hwdata[EV_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // read data prepared in the address phase so hrdata comes from a flop
    // unmapped offsets read zero
    always_comb begin
        rdData_d = 32'h0000_0000;
        case (haddr[7:0])
            OFS_MASK: rdData_d[NUM_SRC-1:0] = mask_q;
            OFS_VECBASE: rdData_d[ADDR_W-1:0] = vecBase_q;
            OFS_COND: begin
                rdData_d[NUM_SRC-1:0] = cond;
                rdData_d[COND_INSERV_BIT] = inService;
                rdData_d[COND_ACT_LSB +: IDX_W] = active_q;
            end
            OFS_VECADDR: rdData_d[ADDR_W-1:0] = vectorAddr;
            OFS_EVSTAT: rdData_d[EV_W-1:0] = evStat_q;
            OFS_EVMASK: rdData_d[EV_W-1:0] = evMask_q;
            default: rdData_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdData_q <= '0;
        end else if (addrAccept && !hwrite) begin
            rdData_q <= rdData_d;
        end
    end
    assign hrdata = rdData_q;

    // sticky events cleared by a read; a same-cycle event wins over the clear
    // a stray return only sets its bit
    assign evRead = addrAccept && !hwrite && haddr[7:0] == OFS_EVSTAT;
    assign evNext = (evRead ? '0 : evStat_q) | {strayRet, leave, enter};
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            evStat_q <= '0;
        end else begin
            evStat_q <= evNext;
        end
    end

    // level interrupt while any unmasked event bit stands
    // uses the next status, so no lag
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(evNext & evMask_q);
        end
    end

    // upper address bits and size are not decoded
    logic unusedBits;
    assign unusedBits = ^{haddr[31:8], hsize};
endmodule // prioritized_interrupt_unit
`default_nettype wire

// ==== verification/prioritized_interrupt_unit_asserts.sv ====
// Purpose: concurrent checks on the interrupt unit ports
// Assumes: one clock domain, sys_rst async active high
// Notes: serial and parallel checks skip cycles where entry may fire
`timescale 1ns/100ps
`default_nettype none
module prioritized_interrupt_unit_asserts
    import irq_unit_pkg::*;
(
    input wire logic clk, // core clock
    input wire logic sys_rst, // reset
    input wire logic ext_irq_one, // pin one
    input wire logic ext_irq_two, // pin two
    input wire logic parRegLoad, // load strobe
    input wire logic parRegRead, // read strobe
    input wire logic ser_in_full, // serial in flag
    input wire logic ser_out_empty, // serial out flag
    input wire logic instrBoundary, // boundary
    input wire logic ireturnExec, // return strobe
    input wire logic [ACC_W-1:0] accIn0, // live acc
    input wire logic [DAUC_W-1:0] daucIn, // live control
    input wire logic [HIDDEN_W-1:0] hiddenIn, // live hidden
    input wire logic vectorTake, // entry pulse
    input wire logic restoreStrobe, // restore pulse
    input wire logic [ACC_W-1:0] accSaved0, // saved acc
    input wire logic [DAUC_W-1:0] daucSaved, // saved control
    input wire logic [HIDDEN_W-1:0] hiddenSaved, // saved hidden
    input wire logic inService, // busy
    input wire logic [NUM_SRC-1:0] condFlags // conditions
);
    // a set in the same edge wins over an entry's clear, yet cycles where entry may fire are skipped
    wire logic noTake = !(instrBoundary && !inService);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_take_idle;
        vectorTake |-> !$past(inService) && $past(instrBoundary) && $past(condFlags) != 6'h00;
    endproperty
    a_take_idle: assert property (p_take_idle)
        else $error("entry taken while busy or without cause");
    property p_take_hold;
        vectorTake |-> inService ##1 (!vectorTake && (inService || restoreStrobe)) [*2];
    endproperty
    a_take_hold: assert property (p_take_hold)
        else $error("entry pulse or service level wrong");
    property p_ctx;
        vectorTake |-> accSaved0 == $past(accIn0) && daucSaved == $past(daucIn)
            && hiddenSaved == $past(hiddenIn);
    endproperty
    a_ctx: assert property (p_ctx)
        else $error("context not saved on entry");
    property p_restore;
        inService && ireturnExec |=> restoreStrobe && !inService;
    endproperty
    a_restore: assert property (p_restore)
        else $error("return did not restore");
    property p_no_restore;
        !inService |=> !restoreStrobe;
    endproperty
    a_no_restore: assert property (p_no_restore)
        else $error("restore while idle");
    property p_ext_one;
        condFlags[0] == $past(ext_irq_one, 2);
    endproperty
    a_ext_one: assert property (p_ext_one)
        else $error("pin one condition wrong");
    property p_ext_two;
        condFlags[5] == $past(ext_irq_two, 2);
    endproperty
    a_ext_two: assert property (p_ext_two)
        else $error("pin two condition wrong");
    property p_par_full;
        parRegLoad && noTake |=> condFlags[1];
    endproperty
    a_par_full: assert property (p_par_full)
        else $error("load did not raise full");
    property p_par_empty;
        parRegRead && noTake |=> condFlags[2];
    endproperty
    a_par_empty: assert property (p_par_empty)
        else $error("read did not raise empty");
    property p_ser_in;
        $rose(ser_in_full) && noTake |=> condFlags[3];
    endproperty
    a_ser_in: assert property (p_ser_in)
        else $error("serial in not raised");
    property p_ser_out;
        $rose(ser_out_empty) && noTake |=> condFlags[4];
    endproperty
    a_ser_out: assert property (p_ser_out)
        else $error("serial out not raised");
endmodule // prioritized_interrupt_unit_asserts
`default_nettype wire

// ==== verification/irq_source_model.sv ====
// Purpose: request sources around the interrupt unit
// Assumes: on-chip strobes are one clock long
// Notes: pins change only just after a rising edge
`timescale 1ns/100ps
`default_nettype none
module irq_source_model (
    input wire logic clk, // core clock
    output logic extOne, // request pin one
    output logic extTwo, // request pin two
    output logic parLoad, // parallel load strobe
    output logic parRead, // parallel read strobe
    output logic serIn, // serial in flag
    output logic serOut // serial out flag
);
    // all sources quiet at time zero
    initial begin
        extOne = 1'b0;
        extTwo = 1'b0;
        parLoad = 1'b0;
        parRead = 1'b0;
        serIn = 1'b0;
        serOut = 1'b0;
    end
    // levels are held until the bench drops them once their entry is taken
    task automatic setExt(input logic one, input logic two);
        @(posedge clk);
        extOne <= one;
        extTwo <= two;
    endtask
    // one-clock strobes; both may come together
    task automatic pulsePar(input logic ld, input logic rd);
        @(posedge clk);
        parLoad <= ld;
        parRead <= rd;
        @(posedge clk);
        parLoad <= 1'b0;
        parRead <= 1'b0;
    endtask
    task automatic setSer(input logic i, input logic o);
        @(posedge clk);
        serIn <= i;
        serOut <= o;
    endtask
endmodule // irq_source_model
`default_nettype wire

// ==== verification/test_prioritized_interrupt_unit.sv ====
// Purpose: self-checking bench for the interrupt unit
// Assumes: zero wait bus, boundary driven by the bench
// Notes: one task per scenario
`timescale 1ns/100ps
`default_nettype none
module test_prioritized_interrupt_unit
    import irq_unit_pkg::*;
;
    logic clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
    logic [1:0] htrans = 2'h0, hresp;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, instrBoundary = 1'b0, ireturnExec = 1'b0;
    logic [39:0] ctx = 40'h00_0000_0000;
    wire logic extOne, extTwo, parLoad, parRead, serIn, serOut;
    logic vectorTake, restoreStrobe, inService, irq;
    logic [ADDR_W-1:0] vectorAddr;
    logic [ACC_W-1:0] accSaved0, accSaved1, accSaved2, accSaved3;
    logic [DAUC_W-1:0] daucSaved;
    logic [HIDDEN_W-1:0] hiddenSaved;
    logic [NUM_SRC-1:0] condFlags;
    int n_mismatch = 0, n_checks = 0, k;
    localparam logic [ADDR_W-1:0] BASE = 24'h00_1000;
    always #5 clk = ~clk;
    irq_source_model src (.clk(clk), .extOne(extOne), .extTwo(extTwo), .parLoad(parLoad),
        .parRead(parRead), .serIn(serIn), .serOut(serOut));
    prioritized_interrupt_unit dut (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_irq_one(extOne),
        .ext_irq_two(extTwo), .parRegLoad(parLoad), .parRegRead(parRead), .ser_in_full(serIn),
        .ser_out_empty(serOut), .instrBoundary(instrBoundary), .ireturnExec(ireturnExec),
        .accIn0(ctx), .accIn1(~ctx), .accIn2({ctx[19:0], ctx[39:20]}), .accIn3(ctx ^ 40'hA5),
        .daucIn(ctx[7:0]), .hiddenIn(ctx[39:8]), .vectorTake(vectorTake),
        .vectorAddr(vectorAddr), .restoreStrobe(restoreStrobe), .accSaved0(accSaved0),
        .accSaved1(accSaved1), .accSaved2(accSaved2), .accSaved3(accSaved3),
        .daucSaved(daucSaved),
        .hiddenSaved(hiddenSaved), .inService(inService), .condFlags(condFlags), .irq(irq));
    task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // single AHB-Lite word transfer; waits on hreadyout, never a fixed count
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1 && ++n < 50);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1 && ++n < 100);
        rd = hrdata;
        chk("hready", hreadyout, 1'b1);
        chk("hresp", hresp, HRESP_OKAY);
    endtask
    task automatic waitTake;
        k = 0;
        do begin @(posedge clk); #1; end while (vectorTake !== 1'b1 && ++k < 40);
        chk("vectorTake", vectorTake, 1'b1);
    endtask
    // return strobe, then look at the answer one cycle on
    task automatic doReturn;
        @(posedge clk);
        ireturnExec <= 1'b1;
        @(posedge clk);
        ireturnExec <= 1'b0;
        #1;
    endtask
    task automatic t_regs;
        bus(0, OFS_MASK, 0); chk("mask rst", rd, 0);
        bus(0, OFS_VECBASE, 0); chk("base rst", rd, 0);
        bus(0, OFS_EVMASK, 0); chk("evmask rst", rd, 0);
        bus(1, OFS_VECBASE, 32'hFFFF_FFFF); bus(0, OFS_VECBASE, 0); chk("base rw", rd, 32'h00FF_FFFF);
        bus(1, OFS_COND, 32'hFFFF_FFFF); bus(0, OFS_COND, 0); chk("cond ro", rd, 0);
        bus(0, 8'h18, 0); chk("unmapped", rd, 0);
        $display("test regs done");
    endtask
    // all six pending at once: served strictly in order, never preempted
    task automatic t_prio;
        bus(1, OFS_VECBASE, {8'h00, BASE});
        bus(1, OFS_MASK, 32'h0000_003F);
        src.setExt(1, 1);
        src.pulsePar(1, 1);
        src.setSer(1, 1);
        repeat (4) @(posedge clk);
        instrBoundary <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            waitTake();
            chk("vectorAddr", vectorAddr, BASE + 24'(i * 8));
            chk("accSaved0", accSaved0, ctx);
            chk("accSaved1", accSaved1, ~ctx);
            chk("accSaved2", accSaved2, {ctx[19:0], ctx[39:20]});
            chk("accSaved3", accSaved3, ctx ^ 40'hA5);
            if (i == 0) src.setExt(0, 1);
            if (i == 5) src.setExt(0, 0);
            ctx <= ctx + 40'h11_0000_0101;
            k = 0;
            repeat (6) begin @(posedge clk); #1; k += vectorTake; end
            chk("preempt", k, 0);
            doReturn();
            chk("restore", restoreStrobe, 1'b1);
            chk("inService", inService, 1'b0);
        end
        src.setSer(0, 0);
        $display("test priority done");
    endtask
    // masked source stays visible to tests but causes no entry
    task automatic t_mask;
        bus(1, OFS_MASK, 0);
        src.pulsePar(1, 0);
        k = 0;
        repeat (10) begin @(posedge clk); #1; k += vectorTake; end
        chk("masked entry", k, 0);
        bus(0, OFS_COND, 0); chk("cond", rd[8:0], 9'h002);
        bus(1, OFS_MASK, 32'h0000_0002);
        waitTake();
        chk("vectorAddr mask", vectorAddr, BASE + 24'h00_0008);
        doReturn();
        $display("test mask done");
    endtask
    // status set by events, cleared by read, irq follows the mask
    task automatic t_irq;
        bus(0, OFS_EVSTAT, 0);
        bus(1, OFS_EVMASK, 32'h0000_0007);
        repeat (2) @(posedge clk); #1; chk("irq idle", irq, 1'b0);
        doReturn();
        repeat (3) @(posedge clk); #1; chk("irq set", irq, 1'b1);
        bus(0, OFS_EVSTAT, 0); chk("evstat", rd, 32'h0000_0004);
        repeat (2) @(posedge clk); #1; chk("irq clear", irq, 1'b0);
        bus(1, OFS_EVMASK, 32'h0000_0003);
        doReturn();
        repeat (3) @(posedge clk); #1; chk("irq masked", irq, 1'b0);
        bus(0, OFS_EVSTAT, 0); chk("evstat masked", rd, 32'h0000_0004);
        $display("test irq done");
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        t_regs();
        t_prio();
        t_mask();
        t_irq();
        summarize();
    end
    // the whole run is under two hundred cycles; this cuts a hang short
    initial begin
        #100000;
        n_mismatch++;
        summarize();
    end
endmodule // test_prioritized_interrupt_unit
bind prioritized_interrupt_unit prioritized_interrupt_unit_asserts chk (.clk, .sys_rst,
    .ext_irq_one, .ext_irq_two, .parRegLoad, .parRegRead, .ser_in_full, .ser_out_empty,
    .instrBoundary, .ireturnExec, .accIn0, .daucIn, .hiddenIn, .vectorTake, .restoreStrobe,
    .accSaved0, .daucSaved, .hiddenSaved, .inService, .condFlags);
`default_nettype wire
